// ---- hw/iolm_defs.vh ----
// constants for the io line multiplexer
`ifndef IOLM_DEFS_VH
`define IOLM_DEFS_VH

`define IOLM_NUM_LINES 32
`define IOLM_NUM_LINES_SMALL 21
`define IOLM_PERIPH_ID 8'h02

// reset values of the per-line configuration
`define IOLM_RST_GPIO_EN 32'hffffffff
`define IOLM_RST_B_SEL 32'h00000000
`define IOLM_RST_OUT_EN 32'h00000000
`define IOLM_RST_OUT_DATA 32'h00000000
`define IOLM_RST_MULTI_DRV 32'h00000000
`define IOLM_RST_PULLUP_OFF 32'h00000000
`define IOLM_RST_FILTER_EN 32'h00000000
`define IOLM_RST_CHANGE_EN 32'h00000000
`define IOLM_RST_SYNC_MASK 32'h00000000

// peripheral function codes
`define IOLM_FN_W 5
`define IOLM_NUM_FN 24
`define IOLM_FN_NONE 5'h00
`define IOLM_FN_PULSE0 5'h01
`define IOLM_FN_PULSE1 5'h02
`define IOLM_FN_PULSE2 5'h03
`define IOLM_FN_PULSE3 5'h04
`define IOLM_FN_TMR0_A 5'h05
`define IOLM_FN_TMR0_B 5'h06
`define IOLM_FN_USART0_CLK 5'h07
`define IOLM_FN_TWO_WIRE_DATA 5'h08
`define IOLM_FN_SPI_CS0 5'h09
`define IOLM_FN_SPI_CS1 5'h0a
`define IOLM_FN_SPI_CS2 5'h0b
`define IOLM_FN_SPI_CS3 5'h0c
`define IOLM_FN_SPI_MISO 5'h0d
`define IOLM_FN_SPI_MOSI 5'h0e
`define IOLM_FN_SPI_CLK 5'h0f
`define IOLM_FN_DBG_RX 5'h10
`define IOLM_FN_DBG_TX 5'h11
`define IOLM_FN_SS_TX_DATA 5'h12
`define IOLM_FN_PROG_CLK1 5'h13
`define IOLM_FN_SS_RX_CLK 5'h14
`define IOLM_FN_SS_RX_FRAME 5'h15
`define IOLM_FN_FAST_INT 5'h16
`define IOLM_FN_EXT_INT0 5'h17

// analog inputs sit on lines 17 to 20
`define IOLM_ANALOG_BASE 17
`define IOLM_NUM_ANALOG 4

`endif

// ---- hw/iolm_line_filter.v ----
// per-line input glitch filter
`timescale 1ns/10ps
`default_nettype none

module iolm_line_filter (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // line
  input wire pad_level,
  input wire filter_en,
  output reg level_r
);

  reg last_r;
  reg level_nxt;

  // with the filter on, a new level is taken only once it has been seen on two edges in a row
  always @* begin
    if (filter_en) begin
      level_nxt = (pad_level == last_r) ? pad_level : level_r; // see RULE6
    end else begin
      level_nxt = pad_level;
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      last_r <= 1'b1;
      level_r <= 1'b1;
    end else begin
      last_r <= pad_level;
      level_r <= level_nxt;
    end
  end

endmodule // iolm_line_filter

`default_nettype wire

// ---- hw/iolm_io_line_multiplexer.v ----
// io line multiplexer: per-line gpio, peripheral a/b select and pad control
`timescale 1ns/10ps
`default_nettype none
`include "iolm_defs.vh"

// Functional notes
// RULE1: handles 32 lines, or 21 in the reduced variant.
// RULE2: each line is gpio, peripheral a or peripheral b.
// RULE3: after reset gpio lines are inputs with pull-up on.
// RULE4: configuration changes through set and clear vectors only.
// RULE5: change detection and options work in every function.
// RULE6: optional filter rejects pulses shorter than a clock step.
// RULE7: multi-drive lines only pull low, otherwise released.
// RULE8: pull-up enable per line.
// RULE9: pin level always visible whatever the line does.
// RULE10: one synchronous write sets and clears several outputs.
// RULE11: an output function selected on many lines drives all of them.
// RULE12: lines 17 to 20 also feed analog inputs 0 to 3.
// RULE13: lines 0 to 3 carry pulse, two-wire, timer, usart clock, cs3.
// RULE14: line 9 debug rx/cs1, line 10 debug tx/cs2.
// RULE15: lines 11 to 14 spi a functions, pulse 0 to 3 b.
// RULE16: lines 19, 20 b are fast and external interrupt 0.
// RULE17: peripheral identifier is 2.
// RULE18: selected peripheral drives value and enable, gpio uses own registers.
module iolm_io_line_multiplexer #(
  parameter NUM_LINES = `IOLM_NUM_LINES
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // configuration set and clear vectors
  input wire [31:0] gpio_en_set,
  input wire [31:0] gpio_en_clr,
  input wire [31:0] b_sel_set,
  input wire [31:0] b_sel_clr,
  input wire [31:0] out_en_set,
  input wire [31:0] out_en_clr,
  input wire [31:0] out_data_set,
  input wire [31:0] out_data_clr,
  input wire [31:0] multi_drv_set,
  input wire [31:0] multi_drv_clr,
  input wire [31:0] pullup_off_set,
  input wire [31:0] pullup_off_clr,
  input wire [31:0] filter_en_set,
  input wire [31:0] filter_en_clr,
  input wire [31:0] change_en_set,
  input wire [31:0] change_en_clr,
  input wire [31:0] sync_mask_set,
  input wire [31:0] sync_mask_clr,
  // synchronous output write
  input wire sync_write,
  input wire [31:0] sync_write_data,
  // change status acknowledge
  input wire [31:0] change_ack,
  // peripheral side
  input wire [`IOLM_NUM_FN-1:0] func_out,
  input wire [`IOLM_NUM_FN-1:0] func_oe,
  output reg [`IOLM_NUM_FN-1:0] func_in_r,
  output reg [`IOLM_NUM_ANALOG-1:0] analog_input_r,
  // pads
  input wire [31:0] pad_in,
  output reg [31:0] pad_out_r,
  output reg [31:0] pad_oe_n_r,
  output reg [31:0] pad_pullup_en_r,
  // status
  output reg [31:0] pin_level_r,
  output reg [31:0] change_status_r,
  output reg change_irq_r,
  output reg [31:0] gpio_en_r,
  output reg [31:0] out_data_r,
  output reg [7:0] periph_id_r
);

  localparam [31:0] LINE_MASK = (NUM_LINES >= 32) ? 32'hffffffff :
    ((32'h00000001 << NUM_LINES) - 32'h00000001);

  reg [31:0] b_sel_r;
  reg [31:0] out_en_r;
  reg [31:0] multi_drv_r;
  reg [31:0] pullup_off_r;
  reg [31:0] filter_en_r;
  reg [31:0] change_en_r;
  reg [31:0] sync_mask_r;
  reg [31:0] prev_level_r;
  reg [31:0] out_data_nxt;
  reg [`IOLM_NUM_FN-1:0] func_in_nxt;
  wire [31:0] filt_level;
  wire [31:0] drv_val;
  wire [31:0] drv_en;
  wire [31:0] change_evt;
  integer k;

  function [31:0] setclr;
    input [31:0] cur;
    input [31:0] set;
    input [31:0] clr;
    begin
      setclr = ((cur & ~clr) | set) & LINE_MASK; // see RULE4 see RULE1
    end
  endfunction

  // peripheral a function on each line
  function [`IOLM_FN_W-1:0] fn_a;
    input integer line;
    begin
      case (line)
        0: fn_a = `IOLM_FN_PULSE0; // see RULE13
        1: fn_a = `IOLM_FN_PULSE1;
        2: fn_a = `IOLM_FN_PULSE2;
        3: fn_a = `IOLM_FN_TWO_WIRE_DATA;
        9: fn_a = `IOLM_FN_DBG_RX; // see RULE14
        10: fn_a = `IOLM_FN_DBG_TX;
        11: fn_a = `IOLM_FN_SPI_CS0; // see RULE15
        12: fn_a = `IOLM_FN_SPI_MISO;
        13: fn_a = `IOLM_FN_SPI_MOSI;
        14: fn_a = `IOLM_FN_SPI_CLK;
        17: fn_a = `IOLM_FN_SS_TX_DATA;
        19: fn_a = `IOLM_FN_SS_RX_CLK; // see RULE16
        20: fn_a = `IOLM_FN_SS_RX_FRAME;
        default: fn_a = `IOLM_FN_NONE;
      endcase
    end
  endfunction

  // peripheral b function on each line
  function [`IOLM_FN_W-1:0] fn_b;
    input integer line;
    begin
      case (line)
        0: fn_b = `IOLM_FN_TMR0_A; // see RULE13
        1: fn_b = `IOLM_FN_TMR0_B;
        2: fn_b = `IOLM_FN_USART0_CLK;
        3: fn_b = `IOLM_FN_SPI_CS3;
        9: fn_b = `IOLM_FN_SPI_CS1; // see RULE14
        10: fn_b = `IOLM_FN_SPI_CS2;
        11: fn_b = `IOLM_FN_PULSE0; // see RULE15
        12: fn_b = `IOLM_FN_PULSE1;
        13: fn_b = `IOLM_FN_PULSE2;
        14: fn_b = `IOLM_FN_PULSE3;
        17: fn_b = `IOLM_FN_PROG_CLK1;
        19: fn_b = `IOLM_FN_FAST_INT; // see RULE16
        20: fn_b = `IOLM_FN_EXT_INT0;
        default: fn_b = `IOLM_FN_NONE;
      endcase
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_line
      localparam [`IOLM_FN_W-1:0] FA = fn_a(i);
      localparam [`IOLM_FN_W-1:0] FB = fn_b(i);
      wire [`IOLM_FN_W-1:0] fsel;
      wire fval;
      wire fen;
      wire val;
      wire en;

      iolm_line_filter u_filter (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pad_level(pad_in[i]),
        .filter_en(filter_en_r[i]),
        .level_r(filt_level[i])
      );

      assign fsel = b_sel_r[i] ? FB : FA; // see RULE2
      // the same output function may appear on several lines
      assign fval = (fsel == `IOLM_FN_NONE) ? 1'b0 : func_out[fsel]; // see RULE11
      assign fen = (fsel == `IOLM_FN_NONE) ? 1'b0 : func_oe[fsel];
      assign val = gpio_en_r[i] ? out_data_r[i] : fval; // see RULE18
      assign en = gpio_en_r[i] ? out_en_r[i] : fen;
      // multi-drive releases the line instead of driving it high
      assign drv_val[i] = multi_drv_r[i] ? 1'b0 : val; // see RULE7
      assign drv_en[i] = (i < NUM_LINES) && en && !(multi_drv_r[i] && val);
      assign change_evt[i] = change_en_r[i] && (filt_level[i] != prev_level_r[i]); // see RULE5
    end
  endgenerate

  always @* begin
    out_data_nxt = setclr(out_data_r, out_data_set, out_data_clr);
    if (sync_write) begin
      out_data_nxt = ((out_data_nxt & ~sync_mask_r) |
        (sync_write_data & sync_mask_r)) & LINE_MASK; // see RULE10
    end
  end

  // an input function listens to every line that selects it
  always @* begin
    func_in_nxt = {`IOLM_NUM_FN{1'b0}};
    for (k = 0; k < 32; k = k + 1) begin
      if (k < NUM_LINES && !gpio_en_r[k]) begin
        if (b_sel_r[k]) begin
          func_in_nxt[fn_b(k)] = func_in_nxt[fn_b(k)] | filt_level[k];
        end else begin
          func_in_nxt[fn_a(k)] = func_in_nxt[fn_a(k)] | filt_level[k];
        end
      end
    end
    func_in_nxt[`IOLM_FN_NONE] = 1'b0;
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      gpio_en_r <= `IOLM_RST_GPIO_EN; // see RULE3
      b_sel_r <= `IOLM_RST_B_SEL;
      out_en_r <= `IOLM_RST_OUT_EN;
      out_data_r <= `IOLM_RST_OUT_DATA;
      multi_drv_r <= `IOLM_RST_MULTI_DRV;
      pullup_off_r <= `IOLM_RST_PULLUP_OFF;
      filter_en_r <= `IOLM_RST_FILTER_EN;
      change_en_r <= `IOLM_RST_CHANGE_EN;
      sync_mask_r <= `IOLM_RST_SYNC_MASK;
      prev_level_r <= 32'hffffffff;
      change_status_r <= 32'h00000000;
      change_irq_r <= 1'b0;
      pin_level_r <= 32'hffffffff;
      pad_out_r <= 32'h00000000;
      pad_oe_n_r <= 32'hffffffff;
      pad_pullup_en_r <= 32'hffffffff;
      func_in_r <= {`IOLM_NUM_FN{1'b0}};
      analog_input_r <= {`IOLM_NUM_ANALOG{1'b0}};
      periph_id_r <= 8'h00;
    end else begin
      gpio_en_r <= setclr(gpio_en_r, gpio_en_set, gpio_en_clr);
      b_sel_r <= setclr(b_sel_r, b_sel_set, b_sel_clr);
      out_en_r <= setclr(out_en_r, out_en_set, out_en_clr);
      out_data_r <= out_data_nxt;
      multi_drv_r <= setclr(multi_drv_r, multi_drv_set, multi_drv_clr);
      pullup_off_r <= setclr(pullup_off_r, pullup_off_set, pullup_off_clr);
      filter_en_r <= setclr(filter_en_r, filter_en_set, filter_en_clr);
      change_en_r <= setclr(change_en_r, change_en_set, change_en_clr);
      sync_mask_r <= setclr(sync_mask_r, sync_mask_set, sync_mask_clr);
      prev_level_r <= filt_level;
      // a new change wins over an acknowledge in the same cycle
      change_status_r <= ((change_status_r & ~change_ack) | change_evt) & LINE_MASK;
      change_irq_r <= |(((change_status_r & ~change_ack) | change_evt) & LINE_MASK);
      pin_level_r <= filt_level & LINE_MASK; // see RULE9
      pad_out_r <= drv_val & LINE_MASK;
      pad_oe_n_r <= ~drv_en; // see RULE18
      pad_pullup_en_r <= ~pullup_off_r & LINE_MASK; // see RULE8
      func_in_r <= func_in_nxt;
      analog_input_r <= filt_level[`IOLM_ANALOG_BASE +: `IOLM_NUM_ANALOG]; // see RULE12
      periph_id_r <= `IOLM_PERIPH_ID; // see RULE17
    end
  end

endmodule // iolm_io_line_multiplexer

`default_nettype wire

// ---- dv/iolm_assertions.sv ----
// port assertions for the io line multiplexer
`timescale 1ns/10ps
`default_nettype none
`include "iolm_defs.vh"
module iolm_checker (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // requests
  input wire [31:0] out_data_set,
  input wire [31:0] out_data_clr,
  input wire sync_write,
  input wire [31:0] pullup_off_set,
  input wire [31:0] pad_in,
  // results
  input wire [`IOLM_NUM_ANALOG-1:0] analog_input_r,
  input wire [31:0] pad_oe_n_r,
  input wire [31:0] pad_pullup_en_r,
  input wire [31:0] pin_level_r,
  input wire [31:0] change_status_r,
  input wire change_irq_r,
  input wire [31:0] gpio_en_r,
  input wire [31:0] out_data_r,
  input wire [7:0] periph_id_r
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  AST_ID: assert property ($past(reset_n) |-> periph_id_r == 8'h02)
    else $error("bad id");
  AST_RST: assert property (!$past(reset_n) |-> gpio_en_r == 32'hffffffff &&
    pad_oe_n_r == 32'hffffffff && pad_pullup_en_r == 32'hffffffff)
    else $error("bad reset state");
  AST_SET: assert property (out_data_set[0] && !sync_write |=> out_data_r[0])
    else $error("set lost");
  AST_CLR: assert property (out_data_clr[0] && !out_data_set[0] && !sync_write
    |=> !out_data_r[0])
    else $error("clear lost");
  AST_PULL: assert property (pullup_off_set[5] |-> ##2 !pad_pullup_en_r[5])
    else $error("pull-up still on");
  AST_PIN: assert property (pad_in[0] [*4] |=> pin_level_r[0])
    else $error("pin level stale");
  AST_ANA: assert property (pad_in[17] [*4] |=> analog_input_r[0])
    else $error("analog level stale");
  AST_IRQ: assert property ($rose(|change_status_r) |-> change_irq_r)
    else $error("irq missing");
  COV_IRQ: cover property (change_irq_r);
  COV_OD: cover property ($fell(pad_oe_n_r[10]));
  COV_PIN: cover property ($fell(pin_level_r[0]));
endmodule // iolm_checker
bind iolm_io_line_multiplexer iolm_checker i_chk (.core_clk, .reset_n, .out_data_set,
  .out_data_clr, .sync_write, .pullup_off_set, .pad_in, .analog_input_r, .pad_oe_n_r,
  .pad_pullup_en_r, .pin_level_r, .change_status_r, .change_irq_r, .gpio_en_r,
  .out_data_r, .periph_id_r);
`default_nettype wire

// ---- dv/iolm_pad_model.sv ----
// pin and outside driver model for the io line multiplexer
`timescale 1ns/10ps
`default_nettype none
module iolm_pad_model (
  // clock
  input wire logic core_clk,
  // pad controls
  input wire logic [31:0] pad_out_r,
  input wire logic [31:0] pad_oe_n_r,
  input wire logic [31:0] pad_pullup_en_r,
  // outside drivers
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_en,
  // resolved level
  output wire logic [31:0] pad_in
);
  logic [31:0] float_r = 32'h0;
  // a line with no driver and no pull-up wanders
  always @(posedge core_clk) begin
    float_r <= ~float_r;
  end
  assign pad_in = (~pad_oe_n_r & pad_out_r) | (pad_oe_n_r & ext_en & ext_val) |
    (pad_oe_n_r & ~ext_en & (pad_pullup_en_r | float_r));
endmodule // iolm_pad_model
`default_nettype wire

// ---- dv/iolm_io_line_multiplexer_tb.sv ----
// self-checking bench for the io line multiplexer
`timescale 1ns/10ps
`default_nettype none
`include "iolm_defs.vh"
module iolm_io_line_multiplexer_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] s [9] = '{default: '0};
  logic [31:0] c [9] = '{default: '0};
  logic sync_write = 1'b0;
  logic [31:0] sync_write_data = '0, change_ack = '0, ext_val = '0, ext_en = '0;
  logic [`IOLM_NUM_FN-1:0] func_out = '0, func_oe = '0;
  wire [`IOLM_NUM_FN-1:0] func_in_r;
  wire [`IOLM_NUM_ANALOG-1:0] analog_input_r;
  wire [31:0] pad_in, pad_out_r, pad_oe_n_r, pad_pullup_en_r, pin_level_r;
  wire [31:0] change_status_r, gpio_en_r, out_data_r;
  wire change_irq_r;
  wire [7:0] periph_id_r;
  int err_total = 0;
  int n_tests = 0;
  iolm_io_line_multiplexer #(.NUM_LINES(32)) i_dut (.core_clk, .reset_n,
    .gpio_en_set(s[0]), .gpio_en_clr(c[0]), .b_sel_set(s[1]), .b_sel_clr(c[1]),
    .out_en_set(s[2]), .out_en_clr(c[2]), .out_data_set(s[3]), .out_data_clr(c[3]),
    .multi_drv_set(s[4]), .multi_drv_clr(c[4]), .pullup_off_set(s[5]),
    .pullup_off_clr(c[5]), .filter_en_set(s[6]), .filter_en_clr(c[6]),
    .change_en_set(s[7]), .change_en_clr(c[7]), .sync_mask_set(s[8]),
    .sync_mask_clr(c[8]), .sync_write, .sync_write_data, .change_ack, .func_out,
    .func_oe, .func_in_r, .analog_input_r, .pad_in, .pad_out_r, .pad_oe_n_r,
    .pad_pullup_en_r, .pin_level_r, .change_status_r, .change_irq_r, .gpio_en_r,
    .out_data_r, .periph_id_r);
  iolm_pad_model i_pads (.core_clk, .pad_out_r, .pad_oe_n_r, .pad_pullup_en_r,
    .ext_val, .ext_en, .pad_in);
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one-cycle set/clear pulse, then let the pads follow
  task automatic cfg(input int k, input logic [31:0] sv, input logic [31:0] cv);
    s[k] = sv;
    c[k] = cv;
    wt(1);
    s[k] = '0;
    c[k] = '0;
    wt(2);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    wt(3);
    reset_n = 1'b1;
    wt(1);
    chk(gpio_en_r, 32'hffffffff);
    chk(pad_oe_n_r, 32'hffffffff);
    chk(pad_pullup_en_r, 32'hffffffff);
    chk(pin_level_r, 32'hffffffff);
    chk(periph_id_r, 32'h2);
    cfg(2, 32'h1, 32'h0);
    cfg(3, 32'h1, 32'h0);
    chk({pad_oe_n_r[0], pad_out_r[0]}, 2'b01);
    cfg(3, 32'h0, 32'h1);
    wt(2);
    chk(pin_level_r[0], 1'b0);
    cfg(4, 32'h1, 32'h0);
    cfg(3, 32'h5, 32'h0);
    chk({pad_oe_n_r[0], pad_out_r[0]}, 2'b10);
    cfg(8, 32'h6, 32'h0);
    sync_write = 1'b1;
    sync_write_data = 32'h2;
    wt(1);
    sync_write = 1'b0;
    wt(1);
    chk(out_data_r[2:0], 3'h3);
    cfg(7, 32'h20, 32'h0);
    ext_en[5] = 1'b1;
    for (int i = 0; i < 10 && change_irq_r !== 1'b1; i++) wt(1);
    if (change_irq_r !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    chk(change_status_r, 32'h20);
    change_ack = 32'h20;
    wt(1);
    change_ack = '0;
    wt(1);
    chk(change_status_r, 32'h0);
    cfg(5, 32'h20, 32'h0);
    chk(pad_pullup_en_r[5], 1'b0);
    cfg(6, 32'h40, 32'h0);
    cfg(7, 32'h40, 32'h0);
    ext_en[6] = 1'b1;
    wt(1);
    ext_en[6] = 1'b0;
    wt(5);
    chk({change_status_r[6], pin_level_r[6]}, 2'b01);
    cfg(0, 32'h0, 32'h600);
    cfg(1, 32'h400, 32'h0);
    ext_en[9] = 1'b1;
    func_out[`IOLM_FN_SPI_CS2] = 1'b1;
    func_oe[`IOLM_FN_SPI_CS2] = 1'b1;
    wt(4);
    chk(func_in_r[`IOLM_FN_DBG_RX], 1'b0);
    chk({pad_oe_n_r[10], pad_out_r[10]}, 2'b01);
    ext_val[9] = 1'b1;
    wt(4);
    chk({func_in_r[`IOLM_FN_DBG_RX], pin_level_r[10:9]}, 3'h7);
    cfg(4, 32'h0, 32'h1);
    cfg(0, 32'h0, 32'h801);
    cfg(1, 32'h800, 32'h0);
    func_out[`IOLM_FN_PULSE0] = 1'b1;
    func_oe[`IOLM_FN_PULSE0] = 1'b1;
    wt(2);
    chk({pad_oe_n_r[11], pad_oe_n_r[0], pad_out_r[11], pad_out_r[0]}, 4'h3);
    ext_en[17] = 1'b1;
    wt(4);
    chk(analog_input_r, 4'he);
    cfg(0, 32'h0, 32'h80000);
    cfg(1, 32'h80000, 32'h0);
    chk(func_in_r[`IOLM_FN_FAST_INT], 1'b1);
    chk(func_in_r[`IOLM_FN_SS_RX_CLK], 1'b0);
    ext_en[19] = 1'b1;
    wt(3);
    chk(func_in_r[`IOLM_FN_FAST_INT], 1'b0);
    // second reset in mid-run with lines configured away from their reset state
    reset_n = 1'b0;
    wt(3);
    reset_n = 1'b1;
    wt(1);
    chk(gpio_en_r, 32'hffffffff);
    chk(pad_oe_n_r, 32'hffffffff);
    chk(pad_pullup_en_r, 32'hffffffff);
    wt(1);
    chk(periph_id_r, 32'h2);
    tally_and_finish();
  end
endmodule // iolm_io_line_multiplexer_tb
`default_nettype wire
